// >>> ccr_regs.sv
// comparator control register bank with per-channel datapaths
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - control bit 7 switches the comparator on, and clear it is off and draws no power.
// - read-only bit 6 shows the result, 1 when positive exceeds negative, or below it if inverted.
// - bit 5 routes the result to its pin, driven only while the pin direction bit is clear, whatever the enable.
// - bit 4 inverts the comparator output, clear passes it straight.
// - bit 3 turns the zero-latency glitch filter on, clear leaves the output raw.
// - with the filter on, a change cannot reverse for a nominal 20 ns.
// - bit 2 picks normal power and high speed when set, low power when clear, and resets to 1.
// - bit 1 turns input hysteresis on.
// - bit 0 makes the timer gate and pin output change only on the timer clock falling edge.
// - second register bit 7 lets a rising result set the channel interrupt flag.
// - second register bit 6 lets a falling result set the channel interrupt flag.
// - bits 5-3 select the positive input, from ground at 111 down to pin 0 at 000.
// - bits 2-0 select the negative input, 111 ground, 110 and 101 floating, 100 to 000 pins 4 to 0.
// - the mirror register shows results 4 to 1 in bits 3 to 0 and zero above.
// - software clears a flag, and an edge arriving during the clear leaves it set.
// - edge detectors still react to enable or polarity changes on a disabled comparator.
module ccr_regs
   import ccr_pkg::*;
#(
   parameter int N_CMP       = 4,   // comparators served
   parameter bit NEG_PIN4_OK = 1'b1 // negative pin 4 exists on this variant
)(
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   input  wire logic [ADDR_W-1:0]       i_addr,
   input  wire logic [DATA_W-1:0]       i_wdata,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   output logic      [DATA_W-1:0]       o_rdata,
   input  wire logic [N_CMP-1:0]        i_cmp_raw,
   input  wire logic                    i_tmr_clk,
   input  wire logic [N_CMP-1:0]        i_pin_dir,
   output logic      [N_CMP-1:0]        o_cmp_enable,
   output logic      [N_CMP-1:0]        o_cmp_speed_power_sel,
   output logic      [N_CMP-1:0]        o_cmp_hysteresis_en,
   output logic      [N_CMP*SEL_W-1:0]  o_cmp_pos_input_sel,
   output logic      [N_CMP*SEL_W-1:0]  o_cmp_neg_input_sel,
   output logic      [N_CMP-1:0]        o_cmp_neg_float,
   output logic      [N_CMP-1:0]        o_tmr_gate,
   output logic      [N_CMP-1:0]        o_pin_out,
   output logic      [N_CMP-1:0]        o_pin_oe_n,
   output logic      [N_CMP-1:0]        o_cmp_irq_flag
);

   // the map and the mirror hold four channels at most
   if (N_CMP < 1 || N_CMP > MAX_CMP) begin : g_bad_n
      $error("ccr_regs: N_CMP must lie between 1 and 4");
   end

   typedef struct packed {
      logic [N_CMP-1:0][DATA_W-1:0] con0;   // first control registers
      logic [N_CMP-1:0][DATA_W-1:0] con1;   // second control registers
      logic [N_CMP-1:0]             flag;   // sticky edge flags
      logic [DATA_W-1:0]            rdata;  // read data, valid one cycle
   } ccr_regs_t;

   ccr_regs_t          q_r;
   ccr_regs_t          q_nxt;
   ccr_chan_if         chif [N_CMP] ();
   logic [N_CMP-1:0]   res;
   logic [N_CMP-1:0]   gate;
   logic [N_CMP-1:0]   rise;
   logic [N_CMP-1:0]   fall;
   logic [N_CMP-1:0]   evt;
   logic [MAX_CMP-1:0] mirror;
   logic [2:0]         sel_idx;
   logic               hit_pair;
   logic               is_con1;

   // one datapath per comparator
   for (genvar g = 0; g < N_CMP; g++) begin : g_chan
      assign chif[g].enable  = q_r.con0[g][CON0_ENABLE];
      assign chif[g].invert  = q_r.con0[g][CON0_INVERT];
      assign chif[g].filt_en = q_r.con0[g][CON0_FILTER];
      assign chif[g].sync_en = q_r.con0[g][CON0_SYNC];
      assign res[g]          = chif[g].result;
      assign gate[g]         = chif[g].gate_out;
      assign rise[g]         = chif[g].rise;
      assign fall[g]         = chif[g].fall;

      ccr_chan u_chan (
         .i_clk     (i_clk),
         .i_rst     (i_rst),
         .i_cmp_raw (i_cmp_raw[g]),
         .i_tmr_clk (i_tmr_clk),
         .bus       (chif[g].chan)
      );

      // enabled edges feed the sticky flag
      assign evt[g] = (rise[g] & q_r.con1[g][CON1_RISE_EN])
                    | (fall[g] & q_r.con1[g][CON1_FALL_EN]);

      // analog core controls straight from the registers
      assign o_cmp_enable[g]          = q_r.con0[g][CON0_ENABLE];
      assign o_cmp_speed_power_sel[g] = q_r.con0[g][CON0_SPEED];
      assign o_cmp_hysteresis_en[g]   = q_r.con0[g][CON0_HYST];
      assign o_cmp_pos_input_sel[g*SEL_W +: SEL_W] =
         q_r.con1[g][CON1_POS_LSB +: SEL_W];
      assign o_cmp_neg_input_sel[g*SEL_W +: SEL_W] =
         q_r.con1[g][CON1_NEG_LSB +: SEL_W];

      // floating codes, plus pin 4 where the variant lacks it
      assign o_cmp_neg_float[g] =
         (q_r.con1[g][CON1_NEG_LSB +: SEL_W] == NEG_SEL_OPEN) ||
         (q_r.con1[g][CON1_NEG_LSB +: SEL_W] == NEG_SEL_RSVD) ||
         (!NEG_PIN4_OK && (q_r.con1[g][CON1_NEG_LSB +: SEL_W] == NEG_SEL_PIN4));

      // pin routing ignores the enable bit on purpose
      assign o_tmr_gate[g] = gate[g];
      assign o_pin_out[g]  = gate[g];
      assign o_pin_oe_n[g] = ~(q_r.con0[g][CON0_ROUTE] & ~i_pin_dir[g]);
      assign o_cmp_irq_flag[g] = q_r.flag[g];
   end

   // mirror of all results, unused channels and upper bits read zero
   always_comb begin
      mirror             = '0;
      mirror[N_CMP-1:0]  = res;
   end

   // address decode of the control pairs
   always_comb begin
      sel_idx  = i_addr[3:1];
      is_con1  = i_addr[0];
      hit_pair = (i_addr < REG_MIRROR) && (32'(sel_idx) < N_CMP);
   end

   // register writes, flag updates and read data
   always_comb begin
      q_nxt = q_r;
      // writes: result bit masked off, mirror has no write path
      if (i_wr && hit_pair) begin
         for (int i = 0; i < N_CMP; i++) begin
            if (32'(sel_idx) == i) begin
               if (is_con1) begin
                  q_nxt.con1[i] = i_wdata;
               end else begin
                  q_nxt.con0[i] = i_wdata & CON0_WMASK;
               end
            end
         end
      end
      // write one to clear, an edge in the same cycle wins
      if (i_wr && (i_addr == REG_FLAGS)) begin
         q_nxt.flag = q_r.flag & ~i_wdata[N_CMP-1:0];
      end
      q_nxt.flag = q_nxt.flag | evt;
      // read data only in the cycle after the strobe
      q_nxt.rdata = '0;
      if (i_rd) begin
         if (hit_pair) begin
            for (int i = 0; i < N_CMP; i++) begin
               if (32'(sel_idx) == i) begin
                  if (is_con1) begin
                     q_nxt.rdata = q_r.con1[i];
                  end else begin
                     q_nxt.rdata = q_r.con0[i];
                     q_nxt.rdata[CON0_RESULT] = res[i];
                  end
               end
            end
         end else if (i_addr == REG_MIRROR) begin
            q_nxt.rdata = {4'h0, mirror};
         end else if (i_addr == REG_FLAGS) begin
            q_nxt.rdata = {4'h0, MAX_CMP'(q_r.flag)};
         end
      end
   end

   // state register, speed bit comes up set
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < N_CMP; i++) begin
            q_r.con0[i] <= CON0_RESET;
            q_r.con1[i] <= CON1_RESET;
         end
         q_r.flag  <= '0;
         q_r.rdata <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign o_rdata = q_r.rdata;

endmodule : ccr_regs
`default_nettype wire

// >>> ccr_pkg.sv
// constants, register map and field layout of the comparator control block
`default_nettype none
package ccr_pkg;

   // register bus geometry
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   localparam int          MAX_CMP         = 4;

   // register map: control pairs at 2n and 2n+1, then mirror and flags
   localparam logic [3:0]  REG_CON0_BASE   = 4'h0;
   localparam logic [3:0]  REG_CON1_BASE   = 4'h1;
   localparam logic [3:0]  REG_STRIDE      = 4'h2;
   localparam logic [3:0]  REG_MIRROR      = 4'h8;
   localparam logic [3:0]  REG_FLAGS       = 4'h9;

   // first control register fields
   localparam int          CON0_ENABLE     = 7;
   localparam int          CON0_RESULT     = 6;
   localparam int          CON0_ROUTE      = 5;
   localparam int          CON0_INVERT     = 4;
   localparam int          CON0_FILTER     = 3;
   localparam int          CON0_SPEED      = 2;
   localparam int          CON0_HYST       = 1;
   localparam int          CON0_SYNC       = 0;

   // second control register fields
   localparam int          CON1_RISE_EN    = 7;
   localparam int          CON1_FALL_EN    = 6;
   localparam int          CON1_POS_LSB    = 3;
   localparam int          CON1_NEG_LSB    = 0;
   localparam int          SEL_W           = 3;

   // reset values and write masks
   localparam logic [7:0]  CON0_RESET      = 8'h04;
   localparam logic [7:0]  CON1_RESET      = 8'h00;
   localparam logic [7:0]  CON0_WMASK      = 8'hBF;

   // negative input codes that leave the input floating, pin 4 only where the variant lacks it
   localparam logic [2:0]  NEG_SEL_OPEN    = 3'h6;
   localparam logic [2:0]  NEG_SEL_RSVD    = 3'h5;
   localparam logic [2:0]  NEG_SEL_PIN4    = 3'h4;

   // glitch filter hold time
   localparam int          CLK_PERIOD_NS   = 40;
   localparam int          ZLF_HOLD_NS     = 20;
   localparam int          ZLF_HOLD_RAW    = (ZLF_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          ZLF_HOLD_CYC    = (ZLF_HOLD_RAW < 1) ? 1 : ZLF_HOLD_RAW;

endpackage : ccr_pkg
`default_nettype wire

// >>> ccr_chan_if.sv
// per-comparator link between the register bank and one channel datapath
`timescale 1ns/1ps
`default_nettype none
interface ccr_chan_if;
   logic enable;      // comparator switched on
   logic invert;      // output polarity inverted
   logic filt_en;     // glitch filter on
   logic sync_en;     // gate/pin output follows timer clock falling edge
   logic result;      // filtered, polarity-corrected result
   logic gate_out;    // result toward timer gate and pin
   logic rise;        // one-cycle pulse on rising result
   logic fall;        // one-cycle pulse on falling result

   modport ctl  (output enable, output invert, output filt_en, output sync_en,
                 input  result, input  gate_out, input  rise, input  fall);
   modport chan (input  enable, input  invert, input  filt_en, input  sync_en,
                 output result, output gate_out, output rise, output fall);
endinterface : ccr_chan_if
`default_nettype wire

// >>> ccr_chan.sv
// one comparator channel: input sync, polarity, glitch filter, timer sync, edges
`timescale 1ns/1ps
`default_nettype none
module ccr_chan
   import ccr_pkg::*;
(
   input  wire logic  i_clk,
   input  wire logic  i_rst,
   input  wire logic  i_cmp_raw,
   input  wire logic  i_tmr_clk,
   ccr_chan_if.chan   bus
);
   localparam int HOLD_W = $clog2(ZLF_HOLD_CYC + 1);
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(ZLF_HOLD_CYC);

   typedef struct packed {
      logic [2:0]        raw_sh;   // raw comparator synchroniser
      logic              raw_st;   // stable raw level
      logic [2:0]        tck_sh;   // timer clock synchroniser
      logic              tck_st;   // stable timer clock level
      logic              filt;     // filtered result
      logic [HOLD_W-1:0] hold;     // reversal block countdown
      logic              synced;   // result latched on timer clock fall
      logic              prev;     // result one cycle ago
   } ccr_chan_t;

   ccr_chan_t q_r;
   ccr_chan_t q_nxt;
   logic      cand;

   // next-state logic
   always_comb begin
      q_nxt        = q_r;
      q_nxt.raw_sh = {q_r.raw_sh[1:0], i_cmp_raw};
      q_nxt.tck_sh = {q_r.tck_sh[1:0], i_tmr_clk};
      // a change counts only once stages two and three agree
      if (q_r.raw_sh[1] == q_r.raw_sh[2]) begin
         q_nxt.raw_st = q_r.raw_sh[2];
      end
      if (q_r.tck_sh[1] == q_r.tck_sh[2]) begin
         q_nxt.tck_st = q_r.tck_sh[2];
      end
      // disabled core reads low, so enable and polarity flips still move the result
      cand = (bus.enable & q_r.raw_st) ^ bus.invert;
      if (q_r.hold != '0) begin
         q_nxt.hold = q_r.hold - HOLD_W'(1);         // reversal blocked
      end else if (cand != q_r.filt) begin
         q_nxt.filt = cand;                           // new level passes at once
         q_nxt.hold = bus.filt_en ? HOLD_LOAD : '0;
      end
      // unfiltered: follow immediately, drop any pending hold
      if (!bus.filt_en) begin
         q_nxt.filt = cand;
         q_nxt.hold = '0;
      end
      // latch on the falling edge of the timer clock
      if (q_r.tck_st && (q_r.tck_sh[1] == q_r.tck_sh[2]) && !q_r.tck_sh[2]) begin
         q_nxt.synced = q_r.filt;
      end
      q_nxt.prev = q_r.filt;
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // outputs toward the register bank
   assign bus.result   = q_r.filt;
   assign bus.gate_out = bus.sync_en ? q_r.synced : q_r.filt;
   assign bus.rise     = q_r.filt & ~q_r.prev;
   assign bus.fall     = ~q_r.filt & q_r.prev;

endmodule : ccr_chan
`default_nettype wire

// >>> ccr_analog_model.sv
// analog comparator cores and timer clock source facing the block
`timescale 1ns/1ps
`default_nettype none
module ccr_analog_model #(
   parameter int N    = 4,
   parameter int TDIV = 4
)(
   input  wire logic         i_clk,
   input  wire logic [N-1:0] i_level,   // wanted decision per comparator
   input  wire logic         i_tmr_run, // timer source runs only when set
   output var  logic [N-1:0] o_raw,
   output var  logic         o_tmr_clk
);
   int           cnt   = 0;
   // start quiet: decisions low, timer source parked high
   logic [N-1:0] raw_q = '0;
   logic         tmr_q = 1'b1;
   assign o_raw     = raw_q;
   assign o_tmr_clk = tmr_q;
   // decisions settle one cycle late, like a real response time
   always @(posedge i_clk) begin
      raw_q <= i_level;
   end
   // a stopped timer source stands still, so no stray falling edge appears
   always @(posedge i_clk) begin
      if (i_tmr_run) begin
         cnt = (cnt + 1) % TDIV;
         if (cnt == 0) begin
            tmr_q <= ~tmr_q;
         end
      end
   end
endmodule : ccr_analog_model
`default_nettype wire

// >>> ccr_regs_props.sv
// concurrent checks on the comparator control block ports
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_props
   import ccr_pkg::*;
#(
   parameter int N_CMP       = 4,
   parameter bit NEG_PIN4_OK = 1'b1
)(
   input wire logic                   i_clk,
   input wire logic                   i_rst,
   input wire logic [ADDR_W-1:0]      i_addr,
   input wire logic [DATA_W-1:0]      i_wdata,
   input wire logic                   i_wr,
   input wire logic                   i_rd,
   input wire logic [DATA_W-1:0]      o_rdata,
   input wire logic [N_CMP-1:0]       i_pin_dir,
   input wire logic [N_CMP-1:0]       o_cmp_enable,
   input wire logic [N_CMP-1:0]       o_cmp_speed_power_sel,
   input wire logic [N_CMP*SEL_W-1:0] o_cmp_pos_input_sel,
   input wire logic [N_CMP*SEL_W-1:0] o_cmp_neg_input_sel,
   input wire logic [N_CMP-1:0]       o_cmp_neg_float,
   input wire logic [N_CMP-1:0]       o_pin_oe_n,
   input wire logic [N_CMP-1:0]       o_cmp_irq_flag
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // channel 0 control writes, the route write built on the plain one
   sequence s_con0_wr;
      i_wr && i_addr == REG_CON0_BASE;
   endsequence
   sequence s_route_wr;
      s_con0_wr ##0 i_wdata[CON0_ROUTE];
   endsequence
   AST_CON0_WRITE: assert property (s_con0_wr |=> o_cmp_enable[0] == $past(i_wdata[CON0_ENABLE])
      && o_cmp_speed_power_sel[0] == $past(i_wdata[CON0_SPEED])) else $error("control write not applied");
   AST_SPEED_AFTER_RESET: assert property ($fell(i_rst) |-> &o_cmp_speed_power_sel)
      else $error("speed select not set by reset");
   AST_CON1_WRITE: assert property (i_wr && i_addr == REG_CON1_BASE |=>
      o_cmp_pos_input_sel[2:0] == $past(i_wdata[5:3]) && o_cmp_neg_input_sel[2:0] == $past(i_wdata[2:0]))
      else $error("input select write not applied");
   AST_NEG_FLOAT: assert property (o_cmp_neg_float[0] == (o_cmp_neg_input_sel[2:0] == NEG_SEL_OPEN
      || o_cmp_neg_input_sel[2:0] == NEG_SEL_RSVD || (!NEG_PIN4_OK && o_cmp_neg_input_sel[2:0] == NEG_SEL_PIN4)))
      else $error("floating input flag wrong");
   AST_ROUTE_DRIVES: assert property (s_route_wr ##1 !i_pin_dir[0] |-> !o_pin_oe_n[0])
      else $error("routed pin not driven");
   AST_DIR_BLOCKS: assert property (i_pin_dir[0] |-> o_pin_oe_n[0])
      else $error("pin driven while set as input");
   AST_FLAG_STICKY: assert property (o_cmp_irq_flag[0] && !(i_wr && i_addr == REG_FLAGS && i_wdata[0])
      |=> o_cmp_irq_flag[0]) else $error("flag dropped without clear");
   AST_MIRROR_HIGH_ZERO: assert property (i_rd && i_addr == REG_MIRROR |=> o_rdata[7:4] == 4'h0)
      else $error("mirror upper bits not zero");
endmodule : ccr_regs_props
bind ccr_regs ccr_regs_props #(.N_CMP(N_CMP), .NEG_PIN4_OK(NEG_PIN4_OK)) u_ccr_regs_props (
   .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_pin_dir(i_pin_dir), .o_cmp_enable(o_cmp_enable),
   .o_cmp_speed_power_sel(o_cmp_speed_power_sel), .o_cmp_pos_input_sel(o_cmp_pos_input_sel),
   .o_cmp_neg_input_sel(o_cmp_neg_input_sel), .o_cmp_neg_float(o_cmp_neg_float),
   .o_pin_oe_n(o_pin_oe_n), .o_cmp_irq_flag(o_cmp_irq_flag));
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the comparator control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ccr_pkg::*;
();
   logic              i_clk = 1'b0;
   logic              i_rst = 1'b1;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic [3:0]        i_pin_dir = 4'hF;
   logic [3:0]        level = 4'h0;
   logic              tmr_run = 1'b0;
   logic              tmr_clk;
   logic [3:0]        raw, flag, gate, oe_n, pin, hyst;
   int                hi;
   logic [DATA_W-1:0] o_rdata;
   logic [7:0]        d, d1;
   int                errors = 0;
   int                num_checks = 0;
   always #20 i_clk = ~i_clk;
   ccr_analog_model u_ccr_analog_model (.i_clk(i_clk), .i_level(level), .i_tmr_run(tmr_run), .o_raw(raw),
      .o_tmr_clk(tmr_clk));
   ccr_regs u_ccr_regs (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_raw(raw), .i_tmr_clk(tmr_clk), .i_pin_dir(i_pin_dir),
      .o_cmp_enable(), .o_cmp_speed_power_sel(), .o_cmp_hysteresis_en(hyst), .o_cmp_pos_input_sel(),
      .o_cmp_neg_input_sel(), .o_cmp_neg_float(), .o_tmr_gate(gate), .o_pin_out(pin), .o_pin_oe_n(oe_n),
      .o_cmp_irq_flag(flag));
   // expected first control word: result bit comes from the channel, not the write
   function automatic logic [7:0] con0_exp(input logic [7:0] v, input logic r);
      return (v & CON0_WMASK) | {1'b0, r, 6'h00};
   endfunction : con0_exp
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // bus cycles: strobes one cycle, read data taken in the following cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, e);
   endtask : rd
   // waits end just past an edge so outputs have landed
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : wait_cyc
   task automatic settle(input logic [3:0] lv);
      @(posedge i_clk);
      level <= lv;
      wait_cyc(10);
   endtask : settle
   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   // watchdog: the whole sequence needs well under 4000 cycles
   initial begin
      repeat (4000) @(posedge i_clk);
      errors++;
      conclude();
   end
   // main sequence
   initial begin
      void'($urandom(32'hAF9D));
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         rd(4'(2 * n), CON0_RESET);
         rd(4'(2 * n + 1), CON1_RESET);
      end
      rd(REG_MIRROR, 8'h00);
      rd(4'hC, 8'h00);
      $display("test reset done");
      // random setups on disabled channels: result shows polarity only
      for (int k = 0; k < 16; k++) begin
         d = 8'($urandom) & 8'h7F;
         d1 = 8'($urandom);
         wr(4'(2 * (k % 4)), d);
         wr(4'(2 * (k % 4) + 1), d1);
         @(posedge i_clk);
         i_pin_dir <= 4'($urandom);
         level <= 4'($urandom);
         wait_cyc(8);
         rd(4'(2 * (k % 4)), con0_exp(d, d[4]));
         rd(4'(2 * (k % 4) + 1), d1);
         chk({7'h0, oe_n[k % 4]}, {7'h0, ~(d[5] & ~i_pin_dir[k % 4])});
         chk({7'h0, hyst[k % 4]}, {7'h0, d[1]});
      end
      $display("test random setup done");
      for (int n = 1; n < 4; n++) wr(4'(2 * n), 8'h00);
      wr(4'h0, 8'h80);
      wr(4'h1, 8'h80);
      settle(4'h0);
      wr(REG_FLAGS, 8'h0F);
      settle(4'h1);
      chk({7'h0, flag[0]}, 8'h01);
      rd(REG_FLAGS, 8'h01);
      rd(REG_MIRROR, 8'h01);
      rd(4'h0, 8'hC0);
      wr(REG_MIRROR, 8'hFF);
      rd(REG_MIRROR, 8'h01);
      wr(REG_FLAGS, 8'h01);
      settle(4'h0);
      chk({7'h0, flag[0]}, 8'h00);
      wr(4'h1, 8'h40);
      settle(4'h1);
      chk({7'h0, flag[0]}, 8'h00);
      settle(4'h0);
      chk({7'h0, flag[0]}, 8'h01);
      wr(4'h0, 8'h90);
      wait_cyc(8);
      rd(4'h0, 8'hD0);
      $display("test edges done");
      // disabled channel still flags the edge made by a polarity change
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h80);
      wait_cyc(8);
      wr(REG_FLAGS, 8'h0F);
      wr(4'h0, 8'h10);
      wait_cyc(8);
      chk({7'h0, flag[0]}, 8'h01);
      $display("test disabled edge done");
      // timer-synchronised gate: frozen while the timer source stands still
      wr(4'h0, 8'h81);
      tmr_run <= 1'b1;
      wait_cyc(20);
      chk({7'h0, gate[0]}, 8'h00);
      @(posedge i_clk);
      tmr_run <= 1'b0;
      wait_cyc(8);
      settle(4'h1);
      chk({7'h0, gate[0]}, 8'h00);
      rd(4'h0, 8'hC1);
      @(posedge i_clk);
      tmr_run <= 1'b1;
      wait_cyc(20);
      chk({7'h0, gate[0]}, 8'h01);
      chk({7'h0, pin[0]}, 8'h01);
      $display("test timer sync done");
      // glitch filter: a one-cycle polarity blip stands one cycle bare, longer while reversal is held
      wr(4'h0, 8'h00);
      for (int f = 0; f < 2; f++) begin
         wr(4'h0, 8'(f) << CON0_FILTER);
         wait_cyc(4);
         @(posedge i_clk);
         i_wr    <= 1'b1;
         i_addr  <= 4'h0;
         i_wdata <= (8'(f) << CON0_FILTER) | 8'h10;
         @(posedge i_clk);
         i_wdata <= 8'(f) << CON0_FILTER;
         @(posedge i_clk);
         i_wr    <= 1'b0;
         hi = 0;
         repeat (8) begin
            #1 hi += int'(gate[0]);
            @(posedge i_clk);
         end
         chk(8'(hi), 8'(f * ZLF_HOLD_CYC + 1));
      end
      $display("test glitch filter done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
